// ==== verilog/snt_pkg.sv ====
/*
 * constants and carriers for the sideband event notice framer and its
 * packet timing guards.
 * assumes one reference clock at 40 MHz shared with the whole link.
 */
// Summary of operation
// [R1] send link notice on link mode change
// [R2] link notice: type 0x00, status, oem, checksum
// [R3] link words copy query response layout
// [R4] send config notice on entering initial state
// [R5] suppress config notice after reset command
// [R6] config notice: type 0x01 then checksum
// [R7] driver notice: type 0x02, status, checksum
// [R8] driver word bit0 running, rest reserved
// [R9] release outputs within 200 us after deselect
// [R10] drive outputs two clocks before packet
// [R11] reach initial state within 2 s
// [R12] start response within 50 ms
// [R13] controller tolerates 2 s silence after reset
// [R14] ignore requests at most 2 s after reset
// [R15] token wait no shorter than 32000 clocks
// [R16] one pending notice per type, sent when selected
`default_nettype none
package snt_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    // clock and timing figures
    localparam longint CLK_HZ          = 40000000;
    localparam longint DESEL_HIZ_US    = 200;
    localparam longint DESEL_HIZ_CYC   = (DESEL_HIZ_US * CLK_HZ) / 1000000;
    localparam int     DRIVE_LEAD_CYC  = 2;
    localparam longint POWERUP_S       = 2;
    localparam longint POWERUP_CYC     = POWERUP_S * CLK_HZ;
    localparam longint RESP_MS         = 50;
    localparam longint RESP_CYC        = (RESP_MS * CLK_HZ) / 1000;
    localparam longint SYNC_RST_S      = 2;
    localparam longint SYNC_RST_CYC    = SYNC_RST_S * CLK_HZ;
    localparam int     TOKEN_WAIT_CYC  = 32000;
    ////////////////////////////////////////////////////////////////////////////////
    // notice layout
    localparam logic [7:0] TYPE_LINK   = 8'h00;
    localparam logic [7:0] TYPE_CFG    = 8'h01;
    localparam logic [7:0] TYPE_DRV    = 8'h02;
    localparam logic [3:0] LEN_LINK    = 4'h4;  // words after header: type, status, oem, sum
    localparam logic [3:0] LEN_CFG     = 4'h2;  // type, sum
    localparam logic [3:0] LEN_DRV     = 4'h3;  // type, status, sum
    localparam int         DRV_RUN_BIT = 0;
    localparam int         CNT_W       = 32;
    // link status words as returned by the query response
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] oemStatus;
    } snt_link_t;
    // one payload word toward the serialiser
    typedef struct packed {
        logic        valid;
        logic        last;
        logic [31:0] data;
    } snt_word_t;
endpackage
`default_nettype wire

// ==== verilog/snt_notice.sv ====
/*
 * notice framer: queues link, config and driver notices, emits their payload
 * words (after the common header) and guards output-enable and reset timing.
 * assumes the header, checksum value and serialiser sit outside; the sink
 * takes a word when wordReady is high.
 */
`timescale 1ns/10ps
`default_nettype none
module snt_notice
    import snt_pkg::*;
#(
    parameter longint DESEL_CYC = DESEL_HIZ_CYC,
    parameter longint PWR_CYC   = POWERUP_CYC,
    parameter longint RESP_LIM  = RESP_CYC,
    parameter longint SRST_CYC  = SYNC_RST_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire snt_link_t   linkNow,        // current link status words
    input  wire logic        drvRunning,     // host driver running level
    input  wire logic        enterInit,      // pulse: entering initial state
    input  wire logic        initByResetCmd, // level with enterInit: reset command cause
    input  wire logic        selected,       // package selected, may drive
    input  wire logic        deselDone,      // pulse: deselect response last bit sent
    input  wire logic        cmdDone,        // pulse: last bit of a command received
    input  wire logic        respStart,      // pulse: first bit of a response sent
    input  wire logic        rstRespDone,    // pulse: reset response last bit sent
    input  wire logic        tokenWait,      // level: waiting for a token
    input  wire logic        tokenSeen,      // pulse: token arrived
    input  wire logic [31:0] checksum,       // checksum for the current notice
    input  wire logic        wordReady,      // sink takes a word
    output snt_word_t        wordOut,        // payload word to the serialiser
    output logic             outEnable_n,    // low while outputs are driven
    output logic             ready,          // initial state reached, commands served
    output logic             ignoreReq,      // requests ignored after reset
    output logic             respLate,       // response limit exceeded
    output logic             tokenTimeout    // token wait expired
);
    ////////////////////////////////////////////////////////////////////////////////
    // state
    typedef enum logic [1:0] {S_IDLE, S_LEAD, S_SEND} snt_state_t;
    snt_state_t      state_q;           // framer state
    snt_link_t       linkPrev_q;        // last reported link words
    logic            drvPrev_q;         // last reported driver state
    logic [2:0]      pend_q;            // pending flags: drv, cfg, link
    logic [1:0]      cur_q;             // notice kind in flight
    logic [3:0]      idx_q;             // payload word index
    logic [1:0]      lead_q;            // drive lead counter
    logic            drive_q;           // outputs driven
    logic [CNT_W-1:0] hizCnt_q;         // deselect to release counter
    logic            hizRun_q;
    logic [CNT_W-1:0] pwrCnt_q;         // power-up counter
    logic [CNT_W-1:0] respCnt_q;        // response timer
    logic            respRun_q;
    logic [CNT_W-1:0] srstCnt_q;        // sync reset window
    logic [15:0]     tokCnt_q;          // token wait counter
    logic            linkChg;
    logic            drvChg;
    logic            cfgEv;
    logic            take;
    logic            lastWord;
    // payload word by kind and index
    function automatic logic [31:0] wordOf(input logic [1:0] k, input logic [3:0] i,
                                           input snt_link_t l, input logic d, input logic [31:0] s);
        logic [31:0] w;
        w = 32'h0;
        unique case (k)
            2'h0: begin
                // [R2] link layout order
                if (i == 4'h0) w = {24'h0, TYPE_LINK};
                else if (i == 4'h1) w = l.status;
                else if (i == 4'h2) w = l.oemStatus;
                else w = s;
            end
            2'h1: begin
                // [R6] config layout order
                w = (i == 4'h0) ? {24'h0, TYPE_CFG} : s;
            end
            default: begin
                // [R7] driver layout order
                if (i == 4'h0) w = {24'h0, TYPE_DRV};
                // [R8] running bit only
                else if (i == 4'h1) w = {31'h0, d};
                else w = s;
            end
        endcase
        return w;
    endfunction
    // payload length by kind
    function automatic logic [3:0] lenOf(input logic [1:0] k);
        return (k == 2'h0) ? LEN_LINK : ((k == 2'h1) ? LEN_CFG : LEN_DRV);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // event detection
    // [R1] link mode change
    assign linkChg  = (linkNow != linkPrev_q);
    assign drvChg   = (drvRunning != drvPrev_q);
    // [R5] reset command suppresses
    assign cfgEv    = enterInit && !initByResetCmd;
    assign take     = (state_q == S_SEND) && wordOut.valid && wordReady;  // only a word that stands
    assign lastWord = (idx_q == lenOf(cur_q) - 4'h1);
    // remember reported values; the snapshot is what the notice carries
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            linkPrev_q <= '0;
            drvPrev_q  <= 1'b0;
        end else if (state_q == S_IDLE) begin
            linkPrev_q <= linkNow;
            drvPrev_q  <= drvRunning;
        end
    end
    // pending flags, set wins over clear
    // [R16] one pending per type
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 3'h0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (take && lastWord && cur_q == k[1:0]) pend_q[k] <= 1'b0;
            end
            if (linkChg && state_q == S_IDLE) pend_q[0] <= 1'b1;
            // [R4] initial state entry
            if (cfgEv) pend_q[1] <= 1'b1;
            if (drvChg && state_q == S_IDLE) pend_q[2] <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // framer state machine
    // [R10] two clock drive lead
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            cur_q   <= 2'h0;
            idx_q   <= 4'h0;
            lead_q  <= 2'h0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    // [R16] only while selected
                    if (selected && ready && pend_q != 3'h0) begin
                        cur_q   <= pend_q[0] ? 2'h0 : (pend_q[1] ? 2'h1 : 2'h2);
                        idx_q   <= 4'h0;
                        lead_q  <= 2'h0;
                        state_q <= S_LEAD;
                    end
                end
                S_LEAD: begin
                    lead_q <= lead_q + 2'h1;
                    if (lead_q == 2'(DRIVE_LEAD_CYC - 1)) state_q <= S_SEND;
                end
                S_SEND: begin
                    if (take) begin
                        idx_q <= idx_q + 4'h1;
                        if (lastWord) state_q <= S_IDLE;
                    end
                end
            endcase
        end
    end
    // payload word register
    // [R3] link words passed unchanged
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wordOut <= '0;
        end else begin
            wordOut.valid <= (state_q == S_SEND) && !(take && lastWord);
            wordOut.last  <= (state_q == S_SEND) && (take ? (idx_q + 4'h1 == lenOf(cur_q) - 4'h1) : lastWord);
            wordOut.data  <= wordOf(cur_q, take ? idx_q + 4'h1 : idx_q, linkPrev_q, drvPrev_q, checksum);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // output drive and deselect release
    // [R9] release after deselect
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_q  <= 1'b0;
            hizRun_q <= 1'b0;
            hizCnt_q <= '0;
        end else begin
            if (deselDone) begin
                hizRun_q <= 1'b1;
                hizCnt_q <= '0;
            end else if (hizRun_q) begin
                hizCnt_q <= hizCnt_q + 1'b1;
                if (hizCnt_q == CNT_W'(DESEL_CYC - 2)) hizRun_q <= 1'b0;
            end
            if (deselDone || !selected || (hizRun_q && state_q == S_IDLE)) drive_q <= 1'b0;
            else if (state_q == S_LEAD) drive_q <= 1'b1;
        end
    end
    assign outEnable_n = !drive_q;
    ////////////////////////////////////////////////////////////////////////////////
    // power-up and reset windows, response and token timers
    // [R11] ready within 2 s
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwrCnt_q <= '0;
            ready    <= 1'b0;
        end else if (!ready) begin
            pwrCnt_q <= pwrCnt_q + 1'b1;
            if (pwrCnt_q == CNT_W'(PWR_CYC - 2)) ready <= 1'b1;
        end
    end
    // [R14] bounded ignore window
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            srstCnt_q <= '0;
            ignoreReq <= 1'b0;
        end else if (rstRespDone) begin
            srstCnt_q <= '0;
            ignoreReq <= 1'b1;
        end else if (ignoreReq) begin
            srstCnt_q <= srstCnt_q + 1'b1;
            if (srstCnt_q == CNT_W'(SRST_CYC - 2)) ignoreReq <= 1'b0;
        end
    end
    // [R12] response time watchdog
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            respCnt_q <= '0;
            respRun_q <= 1'b0;
            respLate  <= 1'b0;
        end else begin
            if (cmdDone) begin
                respRun_q <= 1'b1;
                respCnt_q <= '0;
            end else if (respStart) begin
                respRun_q <= 1'b0;
            end else if (respRun_q) begin
                respCnt_q <= respCnt_q + 1'b1;
            end
            respLate <= respRun_q && !respStart && (respCnt_q >= CNT_W'(RESP_LIM - 1));
        end
    end
    // [R15] token timeout floor
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tokCnt_q     <= 16'h0;
            tokenTimeout <= 1'b0;
        end else if (!tokenWait || tokenSeen) begin
            tokCnt_q     <= 16'h0;
            tokenTimeout <= 1'b0;
        end else if (tokCnt_q != 16'(TOKEN_WAIT_CYC)) begin
            tokCnt_q <= tokCnt_q + 16'h1;
        end else begin
            tokenTimeout <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // assertions, all on the reference clock and off during reset
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_lead;
        (state_q == S_LEAD && $past(state_q) == S_IDLE) |-> !wordOut.valid [*2];
    endproperty
    a_lead: assert property (p_lead) else $error("word before drive lead"); // [R10]
    property p_cfgSupp;
        (enterInit && initByResetCmd && !pend_q[1]) |=> !pend_q[1];
    endproperty
    a_cfgSupp: assert property (p_cfgSupp) else $error("config notice not suppressed"); // [R5]
    property p_cfgSet;
        (enterInit && !initByResetCmd) |=> pend_q[1];
    endproperty
    a_cfgSet: assert property (p_cfgSet) else $error("config notice not queued"); // [R4]
    property p_linkSet;
        (linkChg && state_q == S_IDLE) |=> pend_q[0];
    endproperty
    a_linkSet: assert property (p_linkSet) else $error("link notice not queued"); // [R1]
    property p_selOnly;
        (state_q == S_IDLE && !selected) |=> state_q == S_IDLE;
    endproperty
    a_selOnly: assert property (p_selOnly) else $error("notice started unselected"); // [R16]
    property p_type;
        ($rose(wordOut.valid)) |-> wordOut.data[31:8] == 24'h0 &&
            wordOut.data[7:0] == (cur_q == 2'h0 ? TYPE_LINK : (cur_q == 2'h1 ? TYPE_CFG : TYPE_DRV));
    endproperty
    a_type: assert property (p_type) else $error("wrong notice type word"); // [R2]
    property p_drvWord;
        (wordOut.valid && cur_q == 2'h2 && idx_q == 4'h1) |-> wordOut.data == {31'h0, drvPrev_q};
    endproperty
    a_drvWord: assert property (p_drvWord) else $error("driver word malformed"); // [R8]
    property p_cfgLen;
        (wordOut.valid && cur_q == 2'h1 && idx_q == 4'h1) |-> wordOut.last && wordOut.data == checksum;
    endproperty
    a_cfgLen: assert property (p_cfgLen) else $error("config checksum misplaced"); // [R6]
    property p_tok;
        $rose(tokenTimeout) |-> tokCnt_q == 16'(TOKEN_WAIT_CYC);
    endproperty
    a_tok: assert property (p_tok) else $error("token timeout too early"); // [R15]
    c_link: cover property (take && lastWord && cur_q == 2'h0);
    c_cfg:  cover property (take && lastWord && cur_q == 2'h1);
    c_drv:  cover property (take && lastWord && cur_q == 2'h2);
    c_des:  cover property ($fell(hizRun_q));
endmodule
`default_nettype wire

// ==== tb/snt_sink.sv ====
/*
 * sink model of the serialiser toward the management controller: takes
 * payload words from the notice framer, promptly or with random stalls.
 * assumes the shared 40 MHz reference clock and the bench seeding $urandom.
 */
`timescale 1ns/10ps
`default_nettype none
module snt_sink
    import snt_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire logic      rst_n,
    input  wire logic      slow,     // high: stall at random
    input  wire snt_word_t wordOut,  // word offered by the framer
    output var logic       wordReady // word accepted at this edge
);
    ////////////////////////////////////////////////////////////////////////////////
    // ready moves only at the falling edge, away from the sampling edge
    always @(negedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wordReady <= 1'b0;
        end else begin
            wordReady <= !slow || ($urandom_range(3) == 0);
        end
    end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
/*
 * self-checking bench of the notice framer and its timing guards.
 * assumes the sink model above; timing counts other than the token wait shortened through parameters.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import snt_pkg::*;
    localparam longint LIM = 20;  // every shortened count
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    snt_link_t   linkNow = '0;
    logic        drvRunning = 1'b0, enterInit = 1'b0, initByResetCmd = 1'b0, selected = 1'b0;
    logic        deselDone = 1'b0, cmdDone = 1'b0, respStart = 1'b0, rstRespDone = 1'b0;
    logic        tokenWait = 1'b0, tokenSeen = 1'b0, slow = 1'b0;
    logic [31:0] checksum = '0;
    logic        wordReady, outEnable_n, ready, ignoreReq, respLate, tokenTimeout;
    snt_word_t   wordOut;
    logic [32:0] expQ[$];        // expected {last, data} in order
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          leadCnt = 0;    // cycles driven before the first word
    int          n;
    logic        prevValid = 1'b0;
    logic [31:0] cs;
    snt_link_t   lv;
    always #12.5 sys_clk = !sys_clk;
    snt_notice #(.DESEL_CYC(LIM), .PWR_CYC(LIM), .RESP_LIM(LIM), .SRST_CYC(LIM)) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .linkNow(linkNow), .drvRunning(drvRunning),
        .enterInit(enterInit), .initByResetCmd(initByResetCmd), .selected(selected),
        .deselDone(deselDone), .cmdDone(cmdDone), .respStart(respStart), .rstRespDone(rstRespDone),
        .tokenWait(tokenWait), .tokenSeen(tokenSeen), .checksum(checksum), .wordReady(wordReady),
        .wordOut(wordOut), .outEnable_n(outEnable_n), .ready(ready), .ignoreReq(ignoreReq),
        .respLate(respLate), .tokenTimeout(tokenTimeout));
    snt_sink sink_u (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .wordOut(wordOut), .wordReady(wordReady));
    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return ready;
            1: return outEnable_n;
            2: return respLate;
            3: return ignoreReq;
            4: return tokenTimeout;
            default: return logic'(expQ.size() == 0);
        endcase
    endfunction
    // bounded wait for a level, cycles spent in o
    task automatic waitSig(input int s, input logic v, input longint lim, output int o);
        o = 0;
        while (sig(s) !== v && o < lim) begin
            @(negedge sys_clk);
            o++;
        end
        if (sig(s) !== v) begin
            n_mismatch++;
            $display("[ERR] %0t wait ran out", $time);
            close_out();
        end
    endtask
    task automatic pulse(ref logic p);
        p = 1'b1;
        @(negedge sys_clk);
        p = 1'b0;
    endtask
    task automatic note(input logic l, input logic [31:0] d);
        expQ.push_back({l, d});
    endtask
    task automatic noteLink(input snt_link_t v);
        note(1'b0, {24'h0, TYPE_LINK});
        note(1'b0, v.status);
        note(1'b0, v.oemStatus);
        note(1'b1, cs);
    endtask
    task automatic noteDrv(input logic r);
        note(1'b0, {24'h0, TYPE_DRV});
        note(1'b0, {31'h0, r});
        note(1'b1, cs);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // monitor: each accepted word against the oldest note, drive lead time
    always @(posedge sys_clk) begin
        if (rst_n && wordOut.valid === 1'b1 && !prevValid) begin
            chk(leadCnt >= DRIVE_LEAD_CYC, 1'b1);
        end
        if (rst_n && wordOut.valid === 1'b1) chk(outEnable_n, 1'b0);
        if (rst_n && wordOut.valid === 1'b1 && wordReady === 1'b1) begin
            if (expQ.size() == 0) chk(1'b1, 1'b0);
            else chk({wordOut.last, wordOut.data}, expQ.pop_front());
        end
        leadCnt = (outEnable_n === 1'b0) ? leadCnt + 1 : 0;
        prevValid = (wordOut.valid === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(61670));
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        chk(outEnable_n, 1'b1);
        chk(ready, 1'b0);
        waitSig(0, 1'b1, LIM + 5, n);
        $display("test powerup done");
        selected = 1'b1;
        for (int i = 0; i < 3; i++) begin
            slow = i[0];
            lv = {$urandom, $urandom};
            cs = $urandom;
            noteLink(lv);
            checksum = cs;
            linkNow = lv;
            waitSig(5, 1'b1, 300, n);
        end
        $display("test link done");
        initByResetCmd = 1'b1;
        pulse(enterInit);
        initByResetCmd = 1'b0;
        repeat (40) begin
            @(negedge sys_clk);
            chk(wordOut.valid, 1'b0);
        end
        note(1'b0, {24'h0, TYPE_CFG});
        note(1'b1, cs);
        pulse(enterInit);
        waitSig(5, 1'b1, 300, n);
        $display("test config done");
        for (int i = 0; i < 2; i++) begin
            slow = !slow;
            cs = $urandom;
            checksum = cs;
            noteDrv(!drvRunning);
            drvRunning = !drvRunning;
            waitSig(5, 1'b1, 300, n);
        end
        $display("test driver done");
        // pending while deselected, merged events, link before config before driver
        selected = 1'b0;
        cs = $urandom;
        checksum = cs;
        lv = {$urandom, $urandom};
        noteLink(lv);
        note(1'b0, {24'h0, TYPE_CFG});
        note(1'b1, cs);
        noteDrv(!drvRunning);
        linkNow = lv;
        drvRunning = !drvRunning;
        pulse(enterInit);
        pulse(enterInit);
        repeat (30) @(negedge sys_clk);
        chk(outEnable_n, 1'b1);
        selected = 1'b1;
        waitSig(5, 1'b1, 600, n);
        $display("test pending done");
        selected = 1'b0;
        pulse(deselDone);
        waitSig(1, 1'b1, LIM, n);
        repeat (10) @(negedge sys_clk);
        chk(outEnable_n, 1'b1);
        $display("test deselect done");
        pulse(cmdDone);
        repeat (3) @(negedge sys_clk);
        pulse(respStart);
        repeat (LIM + 5) @(negedge sys_clk);
        chk(respLate, 1'b0);
        pulse(cmdDone);
        waitSig(2, 1'b1, LIM + 3, n);
        chk(n >= LIM - 3, 1'b1);
        $display("test response done");
        // ignoring after reset must start within 3 cycles and last LIM - 3 to LIM + 3 cycles
        pulse(rstRespDone);
        waitSig(3, 1'b1, 3, n);
        waitSig(3, 1'b0, LIM + 3, n);
        chk(n >= LIM - 3, 1'b1);
        $display("test sync reset done");
        tokenWait = 1'b1;
        repeat (31990) @(negedge sys_clk);
        chk(tokenTimeout, 1'b0);
        waitSig(4, 1'b1, 40, n);
        pulse(tokenSeen);
        waitSig(4, 1'b0, 3, n);
        tokenWait = 1'b0;
        $display("test token done");
        close_out();
    end
endmodule
`default_nettype wire
